/* rtl/dpd_crc8.sv */
// Serial-equivalent 8-bit CRC over a right-aligned message of up to 24 bits.
// Assumes the caller registers the result; purely combinational.
`timescale 1ns/1ps
`include "dpd_map.svh"
module dpd_crc8
(
    input  wire logic [23:0] msg,   // Message, right aligned
    input  wire logic [4:0]  len,   // Message length in bits
    input  wire logic [7:0]  seed,  // Preset of the shift register
    output logic      [7:0]  crc    // Resulting CRC
);
    // ============================================================
    // Shift message MSB first, then eight zeros to flush
    always_comb
    begin
        logic [23:0] al;
        logic [7:0]  r;
        logic        fb;
        logic        b;
        al = msg << (5'd24 - len);
        r  = seed;
        fb = 1'b0;
        b  = 1'b0;
        for (int i = 0; i < 32; i++)
        begin
            if (i < 32'(len) + 8)
            begin
                // Bits beyond the message are the zero flush
                b  = (i < 32'(len)) ? al[23 - i] : 1'b0;
                fb = r[7];
                r  = {r[6:0], b} ^ (fb ? `DPD_CRC_POLY : 8'h00);
            end
        end
        crc = r;
    end
endmodule // dpd_crc8

/* rtl/dpd_fault_prio.sv */
// Fault priority encoder: picks the most severe active condition.
// Assumes fault levels come from logic on the same clock.
`timescale 1ns/1ps
`include "dpd_map.svh"
module dpd_fault_prio
(
    input  wire logic       user_array_unlocked,
    input  wire logic       selftest_incomplete,
    input  wire logic       selftest_running,
    input  wire logic       selftest_failed,
    input  wire logic       device_status_osc,
    input  wire logic       abs_pressure_over,
    input  wire logic       abs_pressure_under,
    input  wire logic       abs_pressure_disagree,
    input  wire logic       device_status_memtemp,
    input  wire logic       user_otp_fault,
    input  wire logic       user_rw_fault,
    input  wire logic       factory_otp_fault,
    input  wire logic       test_state_flag,
    input  wire logic       device_status_supply,
    input  wire logic       reset_occurred_flag,
    output logic      [3:0] status_code
);
    // ============================================================
    // Highest status code wins, so test most severe first
    always_comb
    begin
        if (reset_occurred_flag)             status_code = 4'hD;
        else if (device_status_supply)       status_code = `DPD_STAT_SUPPLY;
        else if (test_state_flag)            status_code = 4'hB;
        else if (factory_otp_fault)          status_code = 4'hA;
        else if (user_rw_fault)              status_code = 4'h9;
        else if (user_otp_fault)             status_code = `DPD_STAT_FIRST_HARD;
        else if (device_status_memtemp)      status_code = 4'h5;
        else if (abs_pressure_over || abs_pressure_under || abs_pressure_disagree)
            status_code = 4'h4;
        else if (device_status_osc)          status_code = 4'h3;
        else if (selftest_incomplete || selftest_running || selftest_failed)
            status_code = 4'h2;
        else if (user_array_unlocked)        status_code = 4'h1;
        else                                 status_code = `DPD_STAT_NORMAL;
    end
endmodule // dpd_fault_prio

/* rtl/dpd_map.svh */
// Offsets, field positions and codes of the periodic framer.
// Assumes byte offsets on an 8-bit register address; included by bare name.
`ifndef DPD_MAP_SVH
`define DPD_MAP_SVH
// ============================================================
// Register offsets
`define DPD_ADDR_CTRL       8'h00
`define DPD_ADDR_SRC0       8'h04
`define DPD_ADDR_SRC1       8'h08
`define DPD_ADDR_STAT       8'h0C
`define DPD_ADDR_DIAG       8'h10
// ============================================================
// Field positions
`define DPD_CTRL_LOCK       0
`define DPD_CTRL_DIAG       1
`define DPD_CTRL_FRAG       2
`define DPD_CTRL_SILENCE    3
`define DPD_SRC_SID_LSB     0
`define DPD_SRC_FMT_LSB     4
`define DPD_SRC_DTYPE       7
`define DPD_SRC_SIGNED      8
`define DPD_FMT_SID         0
`define DPD_FMT_KAC         1
`define DPD_FMT_STAT        2
// ============================================================
// Codes and lengths
`define DPD_CRC_POLY        8'h2F
`define DPD_CMD_CRC_SEED    8'hFF
`define DPD_CMD_OP_READ     4'h8
`define DPD_ERR_UNSIGNED    10'h000
`define DPD_ERR_SIGNED      10'h200
`define DPD_LEN_BCAST       6'h01
`define DPD_LEN_FRAG_SHORT  6'h02
`define DPD_LEN_FRAG_LONG   6'h04
`define DPD_LEN_CMD_WORD    6'h20
`define DPD_LEN_CRC         6'h08
`define DPD_STAT_NORMAL     4'h0
`define DPD_STAT_FIRST_HARD 4'h8
`define DPD_STAT_SUPPLY     4'hC
`endif

/* rtl/dpd_periodic_rx_tx.sv */
// Periodic collection mode framer with background diagnostic command assembly.
// Assumes a bit decoder upstream delivers whole commands on the clk domain and a
// symbol encoder downstream sends frm_bits; registers sit on a plain port.
//
// Function
// - Modes active only after init lock set
// - Diag off: answer only one-bit broadcast reads
// - Broadcast read bit may be one or zero
// - Diag fragments are 2 or 4 bits
// - Diag on: answer broadcasts and fragments only
// - Broadcast or any length but 2 or 4 clears assembly
// - Diag output only for complete valid word
// - Diag word CRC checked; broadcasts unchecked
// - Frame order: ID, counter, status, data, CRC
// - ID field carries programmed source identifier
// - Wrapping 2-bit counter per source
// - Data field follows per-source type select
// - Every frame ends with 8-bit CRC
// - CRC poly 0x2F, seed zero then ID
// - Status codes 0000 to 0101 encoded
// - Status codes 1000 to 1101 encoded
// - 4-bit status: codes 1000+ send error code
// - Zero-width status: any fault sends error
// - Supply fault: error code or silence
// - Any signed source forces signed error code
`timescale 1ns/1ps
`include "dpd_map.svh"
module dpd_periodic_rx_tx
    import dpd_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        cmd_valid,
    input  wire logic [5:0]  cmd_len,
    input  wire logic [3:0]  cmd_bits,
    input  wire logic        cmd_source,
    input  wire logic [9:0]  sensor_abs,
    input  wire logic [9:0]  sensor_rel,
    input  wire logic        user_array_unlocked,
    input  wire logic        selftest_incomplete,
    input  wire logic        selftest_running,
    input  wire logic        selftest_failed,
    input  wire logic        device_status_osc,
    input  wire logic        abs_pressure_over,
    input  wire logic        abs_pressure_under,
    input  wire logic        abs_pressure_disagree,
    input  wire logic        device_status_memtemp,
    input  wire logic        user_otp_fault,
    input  wire logic        user_rw_fault,
    input  wire logic        factory_otp_fault,
    input  wire logic        test_state_flag,
    input  wire logic        device_status_supply,
    input  wire logic        reset_occurred_flag,
    output logic             frm_valid,
    output logic      [31:0] frm_bits,
    output logic      [5:0]  frm_len,
    output logic             diag_cmd_valid,
    output logic      [31:0] diag_cmd_word,
    output logic             periodic_active
);
    // ============================================================
    // Decode helpers
    // Fragment length chosen by the size select
    function automatic logic [5:0] frag_len(input logic sel);
        frag_len = sel ? `DPD_LEN_FRAG_LONG : `DPD_LEN_FRAG_SHORT;
    endfunction

    // Sort a received command into its class
    function automatic dpd_cmd_e classify(input logic [5:0] len, input logic den, input logic fsel);
        if (len == `DPD_LEN_BCAST)
            classify = DPD_CMD_BCAST;
        else if (den && len == frag_len(fsel))
            classify = DPD_CMD_FRAG;
        else
            classify = DPD_CMD_OTHER;
    endfunction

    // ============================================================
    // State and helper signals
    dpd_state_s   st_reg;        // All registered state
    dpd_state_s   st_next;       // Next value of the state
    dpd_src_cfg_s cfg;           // Config of the addressed source
    dpd_cmd_e     cmd_class;     // Class of the incoming command
    logic [3:0]   status_code;   // Most severe active fault
    logic [9:0]   err_code;      // Error code for the data field
    logic [9:0]   data_val;      // Data field value
    logic         use_err;       // Error code replaces the data
    logic         quiet;         // Supply fault silences answers when silence is set
    logic         answer;        // A frame is due for this command
    logic [23:0]  msg;           // Frame body before the CRC
    logic [4:0]   msg_len;       // Body length in bits
    logic [7:0]   frm_crc;       // CRC of the frame body
    logic [31:0]  asm_new;       // Assembly word with this fragment
    logic [5:0]   cnt_new;       // Assembly count with this fragment
    logic [7:0]   cmd_crc;       // CRC of the assembled command body

    assign cfg       = st_reg.src[cmd_source];
    assign cmd_class = classify(cmd_len, st_reg.diag_en, st_reg.frag_sel);

    // ============================================================
    // Fault priority and CRC engines
    dpd_fault_prio u_prio
    (
        .user_array_unlocked   (user_array_unlocked),
        .selftest_incomplete   (selftest_incomplete),
        .selftest_running      (selftest_running),
        .selftest_failed       (selftest_failed),
        .device_status_osc     (device_status_osc),
        .abs_pressure_over     (abs_pressure_over),
        .abs_pressure_under    (abs_pressure_under),
        .abs_pressure_disagree (abs_pressure_disagree),
        .device_status_memtemp (device_status_memtemp),
        .user_otp_fault        (user_otp_fault),
        .user_rw_fault         (user_rw_fault),
        .factory_otp_fault     (factory_otp_fault),
        .test_state_flag       (test_state_flag),
        .device_status_supply  (device_status_supply),
        .reset_occurred_flag   (reset_occurred_flag),
        .status_code           (status_code)
    );

    // Frame CRC, seeded with four zeros then the source identifier
    dpd_crc8 u_frm_crc
    (
        .msg  (msg),
        .len  (msg_len),
        .seed ({4'h0, cfg.sid}),
        .crc  (frm_crc)
    );

    // Command CRC over the top 24 bits of the assembled word
    dpd_crc8 u_cmd_crc
    (
        .msg  (asm_new[31:8]),
        .len  (5'd24),
        .seed (`DPD_CMD_CRC_SEED),
        .crc  (cmd_crc)
    );

    // ============================================================
    // Frame body assembly
    always_comb
    begin
        // Signed error code wins if any source is signed
        err_code = (st_reg.src[0].signd || st_reg.src[1].signd) ?
                   `DPD_ERR_SIGNED : `DPD_ERR_UNSIGNED;
        // Error substitution depends on the status field width
        if (cfg.fmt[`DPD_FMT_STAT])
            use_err = (status_code >= `DPD_STAT_FIRST_HARD);
        else
            use_err = (status_code != `DPD_STAT_NORMAL);
        quiet    = (status_code == `DPD_STAT_SUPPLY) && st_reg.silence;
        data_val = use_err ? err_code : (cfg.dtype ? sensor_rel : sensor_abs);
        msg      = 24'h000000;
        msg_len  = 5'd0;
        // Fields in send order, each optional one gated by format
        if (cfg.fmt[`DPD_FMT_SID])
        begin
            msg     = {msg[19:0], cfg.sid};
            msg_len = msg_len + 5'd4;
        end
        if (cfg.fmt[`DPD_FMT_KAC])
        begin
            msg     = {msg[21:0], st_reg.keepalive_count[cmd_source]};
            msg_len = msg_len + 5'd2;
        end
        if (cfg.fmt[`DPD_FMT_STAT])
        begin
            msg     = {msg[19:0], status_code};
            msg_len = msg_len + 5'd4;
        end
        msg     = {msg[13:0], data_val};
        msg_len = msg_len + 5'd10;
    end

    // ============================================================
    // Next state: registers, commands, frames
    always_comb
    begin
        st_next            = st_reg;
        st_next.frm_valid  = 1'b0;
        st_next.diag_valid = 1'b0;
        st_next.rdata      = 32'h00000000;
        // Fragment shifted in, MSB first
        asm_new = st_reg.frag_sel ? {st_reg.asm_word[27:0], cmd_bits} :
                                    {st_reg.asm_word[29:0], cmd_bits[1:0]};
        cnt_new = st_reg.asm_cnt + frag_len(st_reg.frag_sel);
        // Periodic answers need the lock; diag fragments also need diag on
        answer  = cmd_valid && st_reg.lock && !quiet &&
                  (cmd_class == DPD_CMD_BCAST || cmd_class == DPD_CMD_FRAG);

        // Register write; lock can only be set, never cleared by software
        if (reg_wr)
        begin
            case (reg_addr)
                `DPD_ADDR_CTRL:
                begin
                    st_next.lock     = st_reg.lock | reg_wdata[`DPD_CTRL_LOCK];
                    st_next.diag_en  = reg_wdata[`DPD_CTRL_DIAG];
                    st_next.frag_sel = reg_wdata[`DPD_CTRL_FRAG];
                    st_next.silence  = reg_wdata[`DPD_CTRL_SILENCE];
                end
                `DPD_ADDR_SRC0:
                    st_next.src[0] = reg_wdata[`DPD_SRC_SIGNED:`DPD_SRC_SID_LSB];
                `DPD_ADDR_SRC1:
                    st_next.src[1] = reg_wdata[`DPD_SRC_SIGNED:`DPD_SRC_SID_LSB];
                default:
                    st_next.lock = st_reg.lock;   // Unmapped writes dropped
            endcase
        end

        // Register read, data valid the next cycle only
        if (reg_rd)
        begin
            case (reg_addr)
                `DPD_ADDR_CTRL:
                    st_next.rdata = {28'h0000000, st_reg.silence, st_reg.frag_sel,
                                     st_reg.diag_en, st_reg.lock};
                `DPD_ADDR_SRC0:
                    st_next.rdata = {23'h000000, st_reg.src[0]};
                `DPD_ADDR_SRC1:
                    st_next.rdata = {23'h000000, st_reg.src[1]};
                `DPD_ADDR_STAT:
                    st_next.rdata = {18'h00000, st_reg.asm_cnt, st_reg.keepalive_count[1],
                                     st_reg.keepalive_count[0], status_code};
                `DPD_ADDR_DIAG:
                    st_next.rdata = st_reg.diag_word;
                default:
                    st_next.rdata = 32'h00000000; // Unmapped reads as zero
            endcase
        end

        // Periodic frame with trailing CRC; counter steps per sent frame
        if (answer)
        begin
            st_next.frm_valid = 1'b1;
            st_next.frm_bits  = {msg, frm_crc};
            st_next.frm_len   = {1'b0, msg_len} + `DPD_LEN_CRC;
            st_next.keepalive_count[cmd_source] = st_reg.keepalive_count[cmd_source] + 2'd1;
        end

        // Diag assembly only while locked and diag enabled
        if (cmd_valid && st_reg.lock && st_reg.diag_en)
        begin
            case (cmd_class)
                DPD_CMD_FRAG:
                begin
                    if (cnt_new == `DPD_LEN_CMD_WORD)
                    begin
                        // Full word: pass on only if CRC and opcode are good
                        if (cmd_crc == asm_new[7:0] &&
                            asm_new[27:24] == `DPD_CMD_OP_READ)
                        begin
                            st_next.diag_valid = 1'b1;
                            st_next.diag_word  = asm_new;
                        end
                        st_next.asm_word = 32'h00000000;
                        st_next.asm_cnt  = 6'h00;
                    end
                    else
                    begin
                        st_next.asm_word = asm_new;
                        st_next.asm_cnt  = cnt_new;
                    end
                end
                DPD_CMD_BCAST:
                begin
                    st_next.asm_word = 32'h00000000;
                    st_next.asm_cnt  = 6'h00;
                end
                default:
                begin
                    // The other fragment size is ignored, not a clear
                    if (cmd_len != `DPD_LEN_FRAG_SHORT && cmd_len != `DPD_LEN_FRAG_LONG)
                    begin
                        st_next.asm_word = 32'h00000000;
                        st_next.asm_cnt  = 6'h00;
                    end
                end
            endcase
        end
    end

    // ============================================================
    // State register
    always_ff @(posedge clk)
    begin
        if (srst)
            st_reg <= '0;
        else
            st_reg <= st_next;
    end

    assign reg_rdata       = st_reg.rdata;
    assign frm_valid       = st_reg.frm_valid;
    assign frm_bits        = st_reg.frm_bits;
    assign frm_len         = st_reg.frm_len;
    assign diag_cmd_valid  = st_reg.diag_valid;
    assign diag_cmd_word   = st_reg.diag_word;
    assign periodic_active = st_reg.lock;

    // ============================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // A command taken while the lock is set
    sequence s_cmd_locked;
        cmd_valid && st_reg.lock && !quiet;
    endsequence

    property p_lock_gate;
        frm_valid |-> $past(st_reg.lock);
    endproperty
    a_lock_gate: assert property (p_lock_gate) else $error("frame sent before lock");

    property p_bcast_only;
        s_cmd_locked ##0 (!st_reg.diag_en && cmd_len != `DPD_LEN_BCAST) |=> !frm_valid;
    endproperty
    a_bcast_only: assert property (p_bcast_only) else $error("non-broadcast answered");

    property p_bcast_any;
        s_cmd_locked ##0 (cmd_len == `DPD_LEN_BCAST) |=> frm_valid;
    endproperty
    a_bcast_any: assert property (p_bcast_any) else $error("broadcast not answered");

    property p_frag_frame;
        s_cmd_locked ##0 (st_reg.diag_en && cmd_len == frag_len(st_reg.frag_sel)) |=> frm_valid;
    endproperty
    a_frag_frame: assert property (p_frag_frame) else $error("fragment not answered");

    property p_clear;
        cmd_valid && st_reg.lock && st_reg.diag_en && cmd_len != `DPD_LEN_FRAG_SHORT &&
        cmd_len != `DPD_LEN_FRAG_LONG |=> st_reg.asm_cnt == 6'h00;
    endproperty
    a_clear: assert property (p_clear) else $error("assembly not cleared");

    property p_diag_full;
        diag_cmd_valid |-> $past(st_reg.asm_cnt) + frag_len($past(st_reg.frag_sel)) == `DPD_LEN_CMD_WORD
                           && st_reg.asm_cnt == 6'h00;
    endproperty
    a_diag_full: assert property (p_diag_full) else $error("diag word incomplete");

    property p_kac_step;
        frm_valid |-> st_reg.keepalive_count[0] == $past(st_reg.keepalive_count[0]) + {1'b0, !$past(cmd_source)} &&
                      st_reg.keepalive_count[1] == $past(st_reg.keepalive_count[1]) + {1'b0, $past(cmd_source)};
    endproperty
    a_kac_step: assert property (p_kac_step) else $error("keepalive not stepped");

    property p_err_sub;
        s_cmd_locked ##0 (answer && use_err) |=> frm_bits[17:8] == $past(err_code);
    endproperty
    a_err_sub: assert property (p_err_sub) else $error("error code not sent");

    property p_silence;
        cmd_valid && quiet |=> !frm_valid && $stable(st_reg.keepalive_count);
    endproperty
    a_silence: assert property (p_silence) else $error("answer during supply silence");

    property p_frame_len;
        frm_valid |-> frm_len >= 6'd18 && frm_len <= 6'd28;
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("frame length wrong");
endmodule // dpd_periodic_rx_tx

/* rtl/dpd_pkg.sv */
// Types shared by the periodic framer modules.
// Assumes the map header is compiled alongside.
package dpd_pkg;
    // ============================================================
    // Types
    // Packed MSB first, so the member order mirrors the register bits
    typedef struct packed {
        logic       signd;     // Source carries signed data
        logic       dtype;     // Data type select
        logic [2:0] fmt;       // Periodic field format
        logic [3:0] sid;       // Source identifier
    } dpd_src_cfg_s;

    typedef enum {DPD_CMD_NONE, DPD_CMD_BCAST, DPD_CMD_FRAG, DPD_CMD_OTHER} dpd_cmd_e;

    typedef struct packed {
        logic                   lock;       // Init complete lock, sticky
        logic                   diag_en;    // Background diag mode enable
        logic                   frag_sel;   // 1: 4-bit fragments
        logic                   silence;    // Supply fault silence
        dpd_src_cfg_s [1:0]     src;        // Per source config
        logic [1:0][1:0]        keepalive_count;        // Keepalive count per source
        logic [31:0]            asm_word;   // Diag command being assembled
        logic [5:0]             asm_cnt;    // Bits assembled so far
        logic [31:0]            rdata;      // Read data register
        logic                   frm_valid;  // Frame strobe
        logic [31:0]            frm_bits;   // Frame, right aligned
        logic [5:0]             frm_len;    // Frame length in bits
        logic                   diag_valid; // Diag command strobe
        logic [31:0]            diag_word;  // Last good diag command
    } dpd_state_s;
endpackage

/* tb/dpd_master_model.sv */
// Bus master stand-in: hands whole commands to the periodic framer.
// Assumes the framer samples the command lines on the rising edge of clk.
`timescale 1ns/1ps
module dpd_master_model
(
    input  wire logic       clk,        // System clock
    output logic            cmd_valid,  // Command strobe
    output logic      [5:0] cmd_len,    // Command length in bits
    output logic      [3:0] cmd_bits,   // Command bits
    output logic            cmd_source  // Answering source
);
    // ============================================================
    // Idle length and bits show junk, never the last command; source holds
    initial
    begin
        cmd_valid = 1'b0;
        {cmd_len, cmd_bits, cmd_source} = 11'h2A5;
    end
    // One command, one cycle; broadcast value free, fragments 2 or 4 bits
    task automatic send(input logic [5:0] l, input logic [3:0] b, input logic s = 1'b0);
        @(posedge clk);
        cmd_valid  <= 1'b1;
        cmd_len    <= l;
        cmd_bits   <= b;
        cmd_source <= s;
        @(posedge clk);
        cmd_valid  <= 1'b0;
        cmd_len    <= ~l;
        cmd_bits   <= ~b;
    endtask
endmodule // dpd_master_model

/* tb/dpd_periodic_rx_tx_tb.sv */
// Self-checking bench of the periodic framer with a master model.
// Assumes the framer answers one cycle after each taken command.
`timescale 1ns/1ps
module dpd_periodic_rx_tx_tb;
    logic clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;   // Clock, reset, strobes
    logic [7:0]  reg_addr = 8'h00;                                  // Register offset
    logic [31:0] reg_wdata = 32'h0, reg_rdata, frm_bits, diag_cmd_word; // Bus and frame
    logic [14:0] flt = 15'h0;                                       // Fault levels
    logic cmd_valid, cmd_source, frm_valid, diag_cmd_valid, periodic_active;
    logic [5:0] cmd_len, frm_len;
    logic [3:0] cmd_bits;
    int n_errors = 0, comparisons = 0;
    always #50 clk = ~clk;
    dpd_master_model u_mst (.clk(clk), .cmd_valid(cmd_valid), .cmd_len(cmd_len), .cmd_bits(cmd_bits),
        .cmd_source(cmd_source));
    dpd_periodic_rx_tx u_dut (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cmd_valid(cmd_valid), .cmd_len(cmd_len),
        .cmd_bits(cmd_bits), .cmd_source(cmd_source), .sensor_abs(10'h1EA), .sensor_rel(10'h2B3),
        .user_array_unlocked(flt[0]), .selftest_incomplete(flt[1]), .selftest_running(flt[2]),
        .selftest_failed(flt[3]), .device_status_osc(flt[4]), .abs_pressure_over(flt[5]),
        .abs_pressure_under(flt[6]), .abs_pressure_disagree(flt[7]), .device_status_memtemp(flt[8]),
        .user_otp_fault(flt[9]), .user_rw_fault(flt[10]), .factory_otp_fault(flt[11]),
        .test_state_flag(flt[12]), .device_status_supply(flt[13]), .reset_occurred_flag(flt[14]),
        .frm_valid(frm_valid), .frm_bits(frm_bits), .frm_len(frm_len), .diag_cmd_valid(diag_cmd_valid),
        .diag_cmd_word(diag_cmd_word), .periodic_active(periodic_active));
    // ============================================================
    // Shared compare, bus and command tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            n_errors++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
        @(posedge clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata & m, exp);
    endtask
    task automatic cmd(input logic [5:0] l, input logic [3:0] b, input logic exp, input logic s = 1'b0);
        u_mst.send(l, b, s);
        #1 chk(frm_valid, exp);
    endtask
    // Whole diag word in 4-bit fragments, MSB first
    task automatic diag(input logic [31:0] w, input logic exp);
        for (int i = 7; i >= 0; i--)
            cmd(6'h04, w[4 * i +: 4], 1'b1);
        chk(diag_cmd_valid, exp);
    endtask
    task automatic wrap_up;
        if (n_errors == 0 && comparisons > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ============================================================
    // Scenarios
    // Lock, worked CRC example, counter, diag off
    task automatic sc_frame;
        cmd(6'h01, 4'h1, 1'b0);
        chk(periodic_active, 32'h0);
        wr(8'h00, 32'h1);
        wr(8'h04, 32'h74);
        cmd(6'h01, 4'h1, 1'b1);
        chk(periodic_active, 32'h1);
        chk(frm_bits, {4'h0, 4'h4, 2'h0, 4'h0, 10'h1EA, 8'h5F});
        chk(frm_len, 32'd28);
        cmd(6'h01, 4'h0, 1'b1);
        chk(frm_bits[23:22], 32'h1);
        chk(frm_bits[17:8], 32'h1EA);
        cmd(6'h02, 4'h2, 1'b0);
        wr(8'h00, 32'h0);
        rd(8'h00, 32'h1, 32'h1);
        rd(8'h20, 32'hFFFFFFFF, 32'h0);
    endtask
    // Fault priority, error substitution, supply fault both ways
    task automatic sc_faults;
        @(posedge clk) flt <= 15'h1200;
        cmd(6'h01, 4'h1, 1'b1);
        chk({frm_bits[21:18], frm_bits[17:8]}, {4'hB, 10'h000});
        @(posedge clk) flt <= 15'h2000;
        cmd(6'h01, 4'h1, 1'b1);
        chk({frm_bits[21:18], frm_bits[17:8]}, {4'hC, 10'h000});
        wr(8'h00, 32'h9);
        cmd(6'h01, 4'h1, 1'b0);
        rd(8'h0C, 32'h3F, 32'h0C);
        @(posedge clk) flt <= 15'h0;
    endtask
    // Fragment sizes, clearing, full word, follow-up reads
    task automatic sc_diag;
        wr(8'h00, 32'h3);
        cmd(6'h02, 4'h1, 1'b1);
        cmd(6'h04, 4'h9, 1'b0);
        cmd(6'h03, 4'h1, 1'b0);
        wr(8'h00, 32'h7);
        cmd(6'h04, 4'hF, 1'b1);
        cmd(6'h01, 4'h1, 1'b1);
        diag(32'h0800009D, 1'b1);
        chk(diag_cmd_word, 32'h0800009D);
        repeat (4) cmd(6'h01, 4'h0, 1'b1);
        diag(32'h0800009C, 1'b0);
        rd(8'h10, 32'hFFFFFFFF, 32'h0800009D);
    endtask
    // Second source: relative data, no status, signed error
    task automatic sc_src1;
        wr(8'h08, 32'h1A5);
        cmd(6'h01, 4'h1, 1'b1, 1'b1);
        chk({frm_bits[19:18], frm_bits[17:8]}, {2'h0, 10'h2B3});
        chk(frm_len, 32'd20);
        @(posedge clk) flt <= 15'h0002;
        cmd(6'h01, 4'h1, 1'b1, 1'b1);
        chk({frm_bits[19:18], frm_bits[17:8]}, {2'h1, 10'h200});
        @(posedge clk) flt <= 15'h0;
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        sc_frame();
        sc_faults();
        sc_diag();
        sc_src1();
        wrap_up();
    end
    initial
    begin
        #200000;
        n_errors++;
        wrap_up();
    end
endmodule // dpd_periodic_rx_tx_tb
